// file: src/bcr_clock_calendar.sv
// bcd clock/calendar with user ram behind a two-wire slave port
// Function
// - time values held as packed bcd
// - date rolls after each month's last day
// - halt bit stops oscillator and timekeeping
// - hours bit 6 selects 12-hour counting
// - 12-hour mode bit 5 is pm flag
// - 24-hour mode bit 5 is tens-of-twenty
// - clock and control at locations 00-07
// - free byte storage at locations 08-3F
// - pointer increments per byte, wraps 3F->00
// - start, device select, location, then stop
// - power fail aborts access, clears pointer
// - timekeeping continues while bus inhibited
// - square wave enable drives selected frequency
// - documented ranges, seconds also holds halt
// - control: out bit7, enable bit4, rate 1:0
// - one second from 32.768 kHz oscillator
// - time set and read at addressed locations
// - disabled square wave shows static out level
// - rate codes 1Hz, 4k, 8k, 32k
// - answer only device address 1101000
// - first write byte loads pointer
`timescale 1ns/10ps
`default_nettype none
module bcr_clock_calendar
	import bcr_pkg::*;
#(
	parameter int OSC_DIV_P = OSC_DIV
) (
	input  wire logic clock,
	input  wire logic rstn,
	input  wire logic crystal_in,
	input  wire logic scl_in,
	input  wire logic sda_in,
	output logic      sda_out,
	output logic      sda_oe,
	input  wire logic power_fail,
	output logic      square_wave_pin_out,
	output logic      square_wave_pin_oe
);
	localparam int PW = $clog2(OSC_DIV_P);
	localparam logic [PW-1:0] PRESC_LAST = PW'(OSC_DIV_P - 1);

	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		bcd_inc = (v[3:0] == 4'h9) ? {4'(v[7:4] + 4'h1), 4'h0} : 8'(v + 8'h01);
	endfunction : bcd_inc

	function automatic logic is_leap(input logic [7:0] y);
		if (!y[4])
			is_leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
		else
			is_leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
	endfunction : is_leap

	function automatic logic [7:0] last_date(input logic [7:0] m, input logic [7:0] y);
		case (m)
			8'h02: last_date = is_leap(y) ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: last_date = 8'h30;
			default: last_date = 8'h31;
		endcase
	endfunction : last_date

	// ---------------- system clock domain: two-wire slave ----------------
	logic      scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d, pf_s1, pf_s2;
	bcr_bus_e  state_reg;
	bcr_byte_e stage_reg;
	logic      rw_reg, mack_ok_reg, sda_oe_reg;
	logic [3:0] bit_cnt_reg;
	logic [7:0] shreg_reg, tx_reg;
	logic [5:0] ptr_reg;
	logic [7:0] ram [RAM_DEPTH];
	bcr_ctl_s  ctl_reg;
	bcr_time_t mirror_reg, stage_data_reg;
	logic [TIME_REGS-1:0] stage_mask_reg;
	bcr_wr_s   xfer_reg;
	logic      wr_req_reg, wa_s1, wa_s2, pub_s1, pub_s2, pub_d;
	bcr_time_t shadow_reg;
	logic      pub_req_reg, wq_seen_reg;

	always_ff @(posedge clock) begin
		if (!rstn) begin
			{scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d} <= 6'h3F;
			{pf_s1, pf_s2} <= 2'h0;
		end else begin
			scl_s1 <= scl_in;
			scl_s2 <= scl_s1;
			scl_d  <= scl_s2;
			sda_s1 <= sda_in;
			sda_s2 <= sda_s1;
			sda_d  <= sda_s2;
			pf_s1  <= power_fail;
			pf_s2  <= pf_s1;
		end
	end

	logic start_det, stop_det, scl_rise, scl_fall, bus_ok, byte_done, addr_hit;
	logic wr_strobe, send_load, ptr_inc, wr_time, wr_busy, launch;
	logic [7:0] rd_byte, ctl_byte;
	logic [5:0] ptr_field;

	assign start_det = scl_s2 && scl_d && sda_d && !sda_s2;
	assign stop_det  = scl_s2 && scl_d && !sda_d && sda_s2;
	assign scl_rise  = scl_s2 && !scl_d;
	assign scl_fall  = !scl_s2 && scl_d;
	assign bus_ok    = !pf_s2 && !start_det && !stop_det;
	assign byte_done = bus_ok && state_reg == ST_RECV && scl_fall && bit_cnt_reg == BITS_PER_BYTE;
	assign addr_hit  = shreg_reg[7:1] == DEV_ADDR;
	assign ptr_field = shreg_reg[5:0];
	assign wr_strobe = byte_done && stage_reg == BY_DATA;
	assign send_load = bus_ok && scl_fall && ((state_reg == ST_ACK && rw_reg) || (state_reg == ST_MACK && mack_ok_reg));
	assign ptr_inc   = wr_strobe || send_load;
	assign wr_time   = wr_strobe && ptr_reg < LOC_CONTROL;
	assign ctl_byte  = {ctl_reg.out_level, 2'h0, ctl_reg.square_wave_enable, 2'h0,
		ctl_reg.rate_select_high, ctl_reg.rate_select_low};

	// time locations answer from the mirror, so a read just after a write sees the old value
	// until the oscillator domain has taken it and published it back
	always_comb begin
		if (ptr_reg < LOC_CONTROL)
			rd_byte = mirror_reg[ptr_reg[2:0]];
		else if (ptr_reg == LOC_CONTROL)
			rd_byte = ctl_byte;
		else
			rd_byte = ram[ptr_reg - LOC_RAM_FIRST];
	end

	always_ff @(posedge clock) begin
		if (!rstn || pf_s2) begin
			state_reg   <= ST_IDLE;
			stage_reg   <= BY_ADDR;
			rw_reg      <= 1'b0;
			mack_ok_reg <= 1'b0;
			sda_oe_reg  <= 1'b0;
			bit_cnt_reg <= 4'h0;
			shreg_reg   <= 8'h00;
			tx_reg      <= 8'h00;
			ptr_reg     <= LOC_SECONDS;
		end else if (start_det) begin
			state_reg   <= ST_RECV;
			stage_reg   <= BY_ADDR;
			bit_cnt_reg <= 4'h0;
			sda_oe_reg  <= 1'b0;
		end else if (stop_det) begin
			state_reg  <= ST_IDLE;
			sda_oe_reg <= 1'b0;
		end else begin
			if (ptr_inc)
				ptr_reg <= 6'(ptr_reg + 6'h01);
			case (state_reg)
				ST_RECV: begin
					if (scl_rise && bit_cnt_reg < BITS_PER_BYTE) begin
						shreg_reg   <= {shreg_reg[6:0], sda_s2};
						bit_cnt_reg <= 4'(bit_cnt_reg + 4'h1);
					end else if (byte_done) begin
						case (stage_reg)
							BY_ADDR: begin
								rw_reg     <= shreg_reg[0];
								sda_oe_reg <= addr_hit;
								state_reg  <= addr_hit ? ST_ACK : ST_IDLE;
							end
							BY_PTR: begin
								ptr_reg    <= ptr_field;
								sda_oe_reg <= 1'b1;
								state_reg  <= ST_ACK;
							end
							default: begin
								sda_oe_reg <= 1'b1;
								state_reg  <= ST_ACK;
							end
						endcase
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						if (rw_reg) begin
							tx_reg      <= rd_byte;
							sda_oe_reg  <= !rd_byte[7];
							bit_cnt_reg <= 4'h1;
							state_reg   <= ST_SEND;
						end else begin
							sda_oe_reg  <= 1'b0;
							bit_cnt_reg <= 4'h0;
							stage_reg   <= (stage_reg == BY_ADDR) ? BY_PTR : BY_DATA;
							state_reg   <= ST_RECV;
						end
					end
				end
				ST_SEND: begin
					if (scl_fall) begin
						if (bit_cnt_reg == BITS_PER_BYTE) begin
							sda_oe_reg <= 1'b0;
							state_reg  <= ST_MACK;
						end else begin
							tx_reg      <= {tx_reg[6:0], 1'b0};
							sda_oe_reg  <= !tx_reg[6];
							bit_cnt_reg <= 4'(bit_cnt_reg + 4'h1);
						end
					end
				end
				ST_MACK: begin
					if (scl_rise)
						mack_ok_reg <= !sda_s2;
					else if (scl_fall && mack_ok_reg) begin
						tx_reg      <= rd_byte;
						sda_oe_reg  <= !rd_byte[7];
						bit_cnt_reg <= 4'h1;
						state_reg   <= ST_SEND;
					end else if (scl_fall)
						state_reg <= ST_IDLE;
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	assign sda_oe  = sda_oe_reg;
	assign sda_out = 1'b0;

	always_ff @(posedge clock) begin
		if (wr_strobe && ptr_reg >= LOC_RAM_FIRST)
			ram[ptr_reg - LOC_RAM_FIRST] <= shreg_reg;
	end

	always_ff @(posedge clock) begin
		if (!rstn)
			ctl_reg <= RST_CONTROL;
		else if (wr_strobe && ptr_reg == LOC_CONTROL)
			ctl_reg <= {shreg_reg[7], shreg_reg[4], shreg_reg[1:0]};
	end

	// time writes are batched: a byte arriving while a batch is in flight waits for the next one
	assign wr_busy = wr_req_reg != wa_s2;
	assign launch  = !wr_busy && stage_mask_reg != '0;

	always_ff @(posedge clock) begin
		if (!rstn) begin
			stage_mask_reg <= '0;
			stage_data_reg <= '0;
			xfer_reg       <= '0;
			wr_req_reg     <= 1'b0;
			{wa_s1, wa_s2} <= 2'h0;
		end else begin
			wa_s1 <= wq_seen_reg;
			wa_s2 <= wa_s1;
			if (launch) begin
				xfer_reg   <= {stage_mask_reg, stage_data_reg};
				wr_req_reg <= !wr_req_reg;
			end
			// a byte landing in the launch cycle keeps its mask bit
			stage_mask_reg <= (launch ? '0 : stage_mask_reg) |
				(wr_time ? 7'(7'h01 << ptr_reg[2:0]) : '0);
			if (wr_time)
				stage_data_reg[ptr_reg[2:0]] <= shreg_reg;
		end
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			{pub_s1, pub_s2, pub_d} <= 3'h0;
			mirror_reg <= {RST_YEAR, RST_MONTH, RST_DATE, RST_DOW, RST_HOURS, RST_MINUTES, RST_SECONDS};
		end else begin
			pub_s1 <= pub_req_reg;
			pub_s2 <= pub_s1;
			pub_d  <= pub_s2;
			if (pub_s2 != pub_d)
				mirror_reg <= shadow_reg;
		end
	end

	// ---------------- oscillator domain: timekeeping and square wave ----------------
	logic      xr_s1, xrstn, wq_s1, wq_s2, pa_s1, pa_s2;
	bcr_ctl_s  ctl_x1, ctl_m, ctl_p, ctl_x2;
	logic [PW-1:0] presc_reg;
	bcr_time_t tm_reg, tm_inc, tm_next;
	logic      wave_reg, halt, tick, wr_apply;
	logic      c_sec, c_min, c_hour, c_date, c_month, mode12, pm_bit;
	logic [4:0] h12;
	logic [5:0] h24;
	logic [7:0] date_last;
	logic      wave_sel, sqw_level, x_out_level;

	always_ff @(posedge crystal_in) begin
		xr_s1 <= rstn;
		xrstn <= xr_s1;
	end

	always_ff @(posedge crystal_in) begin
		if (!xrstn) begin
			{wq_s1, wq_s2, wq_seen_reg, pa_s1, pa_s2} <= 5'h00;
			ctl_x1 <= RST_CONTROL;
			ctl_m  <= RST_CONTROL;
			ctl_p  <= RST_CONTROL;
			ctl_x2 <= RST_CONTROL;
		end else begin
			wq_s1       <= wr_req_reg;
			wq_s2       <= wq_s1;
			wq_seen_reg <= wq_s2;
			pa_s1       <= pub_d;
			pa_s2       <= pa_s1;
			ctl_x1      <= ctl_reg;
			ctl_m       <= ctl_x1;
			ctl_p       <= ctl_m;
			// control bits cross one by one; take the word only once two samples agree
			if (ctl_m == ctl_p)
				ctl_x2 <= ctl_p;
		end
	end

	assign halt     = tm_reg[T_SEC][HALT_BIT];
	assign tick     = !halt && presc_reg == PRESC_LAST;
	assign wr_apply = wq_s2 != wq_seen_reg;
	assign mode12   = tm_reg[T_HOUR][MODE12_BIT];
	assign pm_bit   = tm_reg[T_HOUR][PM_BIT];
	assign h12      = tm_reg[T_HOUR][4:0];
	assign h24      = tm_reg[T_HOUR][5:0];
	assign date_last = last_date(tm_reg[T_MONTH], tm_reg[T_YEAR]);

	// all fields count in bcd; bits outside a field's range are kept as written
	always_comb begin
		tm_inc  = tm_reg;
		c_sec   = tick && tm_reg[T_SEC][6:0] == BCD_59;
		c_min   = c_sec && tm_reg[T_MIN][6:0] == BCD_59;
		c_hour  = c_min && (mode12 ? (h12 == BCD_11 && pm_bit) : h24 == BCD_23);
		c_date  = c_hour && tm_reg[T_DATE] == date_last;
		c_month = c_date && tm_reg[T_MONTH] == MONTH_LAST;
		if (tick)
			tm_inc[T_SEC][6:0] = c_sec ? 7'h00 : 7'(bcd_inc({1'b0, tm_reg[T_SEC][6:0]}));
		if (c_sec)
			tm_inc[T_MIN][6:0] = c_min ? 7'h00 : 7'(bcd_inc({1'b0, tm_reg[T_MIN][6:0]}));
		if (c_min && mode12) begin
			if (h12 == BCD_12)
				tm_inc[T_HOUR][4:0] = BCD_01;
			else if (h12 == BCD_11) begin
				tm_inc[T_HOUR][4:0]   = BCD_12;
				tm_inc[T_HOUR][PM_BIT] = !pm_bit;
			end else
				tm_inc[T_HOUR][4:0] = 5'(bcd_inc({3'h0, h12}));
		end else if (c_min)
			tm_inc[T_HOUR][5:0] = (h24 == BCD_23) ? 6'h00 : 6'(bcd_inc({2'h0, h24}));
		if (c_hour) begin
			tm_inc[T_DOW][2:0] = (tm_reg[T_DOW][2:0] == DOW_LAST) ? 3'h1 : 3'(tm_reg[T_DOW][2:0] + 3'h1);
			tm_inc[T_DATE] = c_date ? BCD_ONE : bcd_inc(tm_reg[T_DATE]);
		end
		if (c_date)
			tm_inc[T_MONTH] = c_month ? BCD_ONE : bcd_inc(tm_reg[T_MONTH]);
		if (c_month)
			tm_inc[T_YEAR] = (tm_reg[T_YEAR] == YEAR_LAST) ? 8'h00 : bcd_inc(tm_reg[T_YEAR]);
	end

	genvar gi;
	generate
		for (gi = 0; gi < TIME_REGS; gi++) begin : g_merge
			assign tm_next[gi] = (wr_apply && xfer_reg.mask[gi]) ? xfer_reg.data[gi] : tm_inc[gi];
		end
	endgenerate

	// the bus never reaches this domain's counting, so inhibiting it leaves time running
	always_ff @(posedge crystal_in) begin
		if (!xrstn) begin
			tm_reg    <= {RST_YEAR, RST_MONTH, RST_DATE, RST_DOW, RST_HOURS, RST_MINUTES, RST_SECONDS};
			presc_reg <= '0;
		end else begin
			tm_reg <= tm_next;
			if (!halt)
				presc_reg <= tick ? '0 : PW'(presc_reg + 1'b1);
		end
	end

	always_ff @(posedge crystal_in) begin
		if (!xrstn) begin
			shadow_reg  <= '0;
			pub_req_reg <= 1'b0;
		end else if (pub_req_reg == pa_s2 && tm_reg != shadow_reg) begin
			shadow_reg  <= tm_reg;
			pub_req_reg <= !pub_req_reg;
		end
	end

	always_comb begin
		case ({ctl_x2.rate_select_high, ctl_x2.rate_select_low})
			RATE_1HZ: wave_sel = presc_reg[PW-1];
			RATE_4K:  wave_sel = presc_reg[2];
			RATE_8K:  wave_sel = presc_reg[1];
			default:  wave_sel = presc_reg[0];
		endcase
	end

	always_ff @(posedge crystal_in) begin
		if (!xrstn)
			wave_reg <= 1'b0;
		else
			wave_reg <= ctl_x2.square_wave_enable ? wave_sel : ctl_x2.out_level;
	end

	// full-rate output has to pass the oscillator itself; it stops with the oscillator
	assign sqw_level = (ctl_x2.square_wave_enable && !halt &&
		{ctl_x2.rate_select_high, ctl_x2.rate_select_low} == RATE_32K) ? crystal_in : wave_reg;
	assign square_wave_pin_out = 1'b0;
	assign square_wave_pin_oe  = !sqw_level;
	assign x_out_level         = ctl_x2.out_level;

	// ---------------- checks ----------------
	sequence s_acking;
		state_reg == ST_ACK && sda_oe_reg;
	endsequence

	property p_ptr_wrap;
		@(posedge clock) disable iff (!rstn) ptr_inc && ptr_reg == LOC_LAST && !pf_s2 |=> ptr_reg == LOC_SECONDS;
	endproperty
	a_ptr_wrap: assert property (p_ptr_wrap) else $error("pointer did not wrap to zero");

	property p_pf_abort;
		@(posedge clock) disable iff (!rstn) pf_s2 |=> state_reg == ST_IDLE && ptr_reg == LOC_SECONDS && !sda_oe_reg;
	endproperty
	a_pf_abort: assert property (p_pf_abort) else $error("power fail did not abort access");

	property p_addr_ack;
		@(posedge clock) disable iff (!rstn) byte_done && stage_reg == BY_ADDR && addr_hit |=> s_acking;
	endproperty
	a_addr_ack: assert property (p_addr_ack) else $error("own address not acknowledged");

	property p_addr_miss;
		@(posedge clock) disable iff (!rstn)
			byte_done && stage_reg == BY_ADDR && !addr_hit |=> state_reg == ST_IDLE && !sda_oe_reg [*2];
	endproperty
	a_addr_miss: assert property (p_addr_miss) else $error("foreign address answered");

	property p_ptr_load;
		@(posedge clock) disable iff (!rstn)
			byte_done && stage_reg == BY_PTR |=> (ptr_reg == $past(ptr_field)) and s_acking;
	endproperty
	a_ptr_load: assert property (p_ptr_load) else $error("location byte not loaded");

	property p_sec_roll;
		@(posedge crystal_in) disable iff (!xrstn)
			tick && tm_reg[T_SEC][6:0] == BCD_59 && !wr_apply |=> tm_reg[T_SEC][6:0] == 7'h00;
	endproperty
	a_sec_roll: assert property (p_sec_roll) else $error("seconds did not roll over");

	property p_halt_freeze;
		@(posedge crystal_in) disable iff (!xrstn) halt && !wr_apply |=> $stable(tm_reg) && $stable(presc_reg);
	endproperty
	a_halt_freeze: assert property (p_halt_freeze) else $error("time moved while halted");

	property p_h24_roll;
		@(posedge crystal_in) disable iff (!xrstn)
			c_min && !mode12 && h24 == BCD_23 && !wr_apply |=> tm_reg[T_HOUR][5:0] == 6'h00;
	endproperty
	a_h24_roll: assert property (p_h24_roll) else $error("24-hour count did not wrap");

	property p_h12_pm;
		@(posedge crystal_in) disable iff (!xrstn)
			c_min && mode12 && h12 == BCD_11 && !wr_apply |=> h12 == BCD_12 && pm_bit != $past(pm_bit);
	endproperty
	a_h12_pm: assert property (p_h12_pm) else $error("pm flag did not toggle at twelve");

	property p_date_roll;
		@(posedge crystal_in) disable iff (!xrstn) c_date && !wr_apply |=> tm_reg[T_DATE] == BCD_ONE;
	endproperty
	a_date_roll: assert property (p_date_roll) else $error("date did not roll to first");

	property p_static_out;
		@(posedge crystal_in) disable iff (!xrstn)
			!ctl_x2.square_wave_enable |=> square_wave_pin_oe == !$past(x_out_level);
	endproperty
	a_static_out: assert property (p_static_out) else $error("static level not on pin");
endmodule : bcr_clock_calendar
`default_nettype wire

// file: src/bcr_pkg.sv
// shared constants and types for the bcd clock/calendar register block
package bcr_pkg;
	localparam int         ADDR_W        = 6;
	localparam logic [5:0] LOC_SECONDS   = 6'h00;
	localparam logic [5:0] LOC_CONTROL   = 6'h07;
	localparam logic [5:0] LOC_RAM_FIRST = 6'h08;
	localparam logic [5:0] LOC_LAST      = 6'h3F;
	localparam int         RAM_DEPTH     = 56;
	localparam int         TIME_REGS     = 7;
	localparam logic [6:0] DEV_ADDR      = 7'h68;
	localparam int         OSC_DIV       = 32768;
	localparam int         HALT_BIT      = 7;
	localparam int         MODE12_BIT    = 6;
	localparam int         PM_BIT        = 5;
	localparam int         T_SEC         = 0;
	localparam int         T_MIN         = 1;
	localparam int         T_HOUR        = 2;
	localparam int         T_DOW         = 3;
	localparam int         T_DATE        = 4;
	localparam int         T_MONTH       = 5;
	localparam int         T_YEAR        = 6;
	localparam logic [7:0] RST_SECONDS   = 8'h80;
	localparam logic [7:0] RST_MINUTES   = 8'h00;
	localparam logic [7:0] RST_HOURS     = 8'h00;
	localparam logic [7:0] RST_DOW       = 8'h01;
	localparam logic [7:0] RST_DATE      = 8'h01;
	localparam logic [7:0] RST_MONTH     = 8'h01;
	localparam logic [7:0] RST_YEAR      = 8'h00;
	localparam logic [6:0] BCD_59        = 7'h59;
	localparam logic [5:0] BCD_23        = 6'h23;
	localparam logic [4:0] BCD_12        = 5'h12;
	localparam logic [4:0] BCD_11        = 5'h11;
	localparam logic [4:0] BCD_01        = 5'h01;
	localparam logic [2:0] DOW_LAST      = 3'h7;
	localparam logic [7:0] MONTH_LAST    = 8'h12;
	localparam logic [7:0] YEAR_LAST     = 8'h99;
	localparam logic [7:0] BCD_ONE       = 8'h01;
	localparam logic [1:0] RATE_1HZ      = 2'h0;
	localparam logic [1:0] RATE_4K       = 2'h1;
	localparam logic [1:0] RATE_8K       = 2'h2;
	localparam logic [1:0] RATE_32K      = 2'h3;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	typedef logic [TIME_REGS-1:0][7:0] bcr_time_t;

	typedef struct packed {
		logic       out_level;
		logic       square_wave_enable;
		logic       rate_select_high;
		logic       rate_select_low;
	} bcr_ctl_s;

	localparam bcr_ctl_s RST_CONTROL = 4'h0;

	typedef struct packed {
		logic [TIME_REGS-1:0] mask;
		bcr_time_t            data;
	} bcr_wr_s;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_RECV = 3'b001,
		ST_ACK  = 3'b010,
		ST_SEND = 3'b011,
		ST_MACK = 3'b100
	} bcr_bus_e;

	typedef enum logic [1:0] {
		BY_ADDR = 2'b00,
		BY_PTR  = 2'b01,
		BY_DATA = 2'b10
	} bcr_byte_e;
endpackage : bcr_pkg

// file: verif/bcr_bus_master.sv
// two-wire bus controller model facing the block's serial port
`timescale 1ns/10ps
`default_nettype none
module bcr_bus_master #(
	parameter int HALF = 10
) (
	input  wire logic  clock,
	input  wire logic  sda_line,
	output logic       scl_line,
	output logic       sda_low,
	output logic       res_valid,
	output logic [7:0] res_data
);
	initial begin
		scl_line = 1'b1;
		sda_low = 1'b0;
		res_valid = 1'b0;
		res_data = 8'h00;
	end
	task automatic hold();
		repeat (HALF) @(posedge clock);
	endtask : hold
	// one pulse per observed ack or byte, so the bench sees results in bus order
	task automatic put(input logic [7:0] v);
		@(posedge clock);
		res_data <= v;
		res_valid <= 1'b1;
		@(posedge clock);
		res_valid <= 1'b0;
	endtask : put
	// also a repeated start when scl is already low
	task automatic start();
		@(posedge clock);
		sda_low <= 1'b0;
		hold();
		scl_line <= 1'b1;
		hold();
		sda_low <= 1'b1;
		hold();
		scl_line <= 1'b0;
		hold();
	endtask : start
	task automatic stop();
		@(posedge clock);
		sda_low <= 1'b1;
		hold();
		scl_line <= 1'b1;
		hold();
		sda_low <= 1'b0;
		hold();
	endtask : stop
	// data changes one cycle after scl falls, held through the high phase
	task automatic bit_io(input logic b, output logic s);
		@(posedge clock);
		sda_low <= ~b;
		hold();
		scl_line <= 1'b1;
		hold();
		s = sda_line;
		scl_line <= 1'b0;
	endtask : bit_io
	task automatic send(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(b[i], s);
		bit_io(1'b1, s);
		ack = ~s;
		put({7'h00, ack});
	endtask : send
	// nack on the last byte ends a read
	task automatic recv(input logic last, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, s);
			b[i] = s;
		end
		bit_io(last, s);
		put(b);
	endtask : recv
endmodule : bcr_bus_master
`default_nettype wire

// file: verif/bcr_clock_calendar_bench.sv
// self-checking bench for the clock/calendar register block
`timescale 1ns/10ps
`default_nettype none
module bcr_clock_calendar_bench
	import bcr_pkg::*;
;
	localparam int DIV = 256;
	logic       clock, rstn, crystal_in, power_fail, scl_line, sda_low, res_valid, sda_oe, sq_oe;
	logic [7:0] res_data, e, m;
	logic [7:0] wr [0:8];
	logic [7:0] rd [0:7];
	logic [7:0] rk [0:7];
	logic [7:0] exp_q [$];
	logic [7:0] msk_q [$];
	logic [31:0] v;
	int         errors, compares, cycles;
	int         dv [0:3] = '{DIV, 8, 4, 1};
	// both lines have pull-ups
	wire logic  sda_line = ~(sda_low | sda_oe);
	wire logic  sq_line = ~sq_oe;

	bcr_clock_calendar #(.OSC_DIV_P(DIV)) i_bcr_clock_calendar (
		.clock(clock), .rstn(rstn), .crystal_in(crystal_in), .scl_in(scl_line), .sda_in(sda_line),
		.sda_out(), .sda_oe(sda_oe), .power_fail(power_fail), .square_wave_pin_out(),
		.square_wave_pin_oe(sq_oe));
	bcr_bus_master i_bcr_bus_master (
		.clock(clock), .sda_line(sda_line), .scl_line(scl_line), .sda_low(sda_low),
		.res_valid(res_valid), .res_data(res_data));

	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	// free-running oscillator, offset so its edges never meet the clock's
	initial begin
		crystal_in = 1'b0;
		#7;
		forever #24 crystal_in = ~crystal_in;
	end
	task automatic fail(input string s);
		errors++;
		$display("Error at %0t: %s", $time, s);
	endtask : fail
	task automatic chk(input logic ok, input string s);
		compares++;
		if (ok !== 1'b1) fail(s);
	endtask : chk
	task automatic put_exp(input logic [7:0] x, input logic [7:0] k);
		exp_q.push_back(x);
		msk_q.push_back(k);
	endtask : put_exp
	task automatic report_and_stop();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : report_and_stop
	task automatic done(input string t);
		if (exp_q.size() != 0) fail("missing result");
		$display("test %s finished", t);
	endtask : done
	task automatic xw(input logic [6:0] d, input int n, input logic k);
		logic a;
		put_exp({7'h00, k}, 8'hFF);
		i_bcr_bus_master.start();
		i_bcr_bus_master.send({d, 1'b0}, a);
		for (int i = 0; i < n; i++) begin
			put_exp({7'h00, k}, 8'hFF);
			i_bcr_bus_master.send(wr[i], a);
		end
		i_bcr_bus_master.stop();
	endtask : xw
	// optional pointer write, then repeated start and read of n bytes
	task automatic xr(input int p, input int n);
		logic a;
		logic [7:0] b;
		if (p >= 0) begin
			put_exp(8'h01, 8'hFF);
			i_bcr_bus_master.start();
			i_bcr_bus_master.send({DEV_ADDR, 1'b0}, a);
			put_exp(8'h01, 8'hFF);
			i_bcr_bus_master.send(p[7:0], a);
		end
		put_exp(8'h01, 8'hFF);
		i_bcr_bus_master.start();
		i_bcr_bus_master.send({DEV_ADDR, 1'b1}, a);
		for (int i = 0; i < n; i++) put_exp(rd[i], rk[i]);
		for (int i = 0; i < n; i++) i_bcr_bus_master.recv(i == n - 1, b);
		i_bcr_bus_master.stop();
	endtask : xr
	task automatic count_edges(input int x);
		int c;
		logic p;
		c = 0;
		p = sq_line;
		repeat (6144) begin
			@(posedge clock);
			if (sq_line === 1'b1 && p === 1'b0) c++;
			p = sq_line;
		end
		chk(c >= x - 1 && c <= x + 1, $sformatf("square edges %0d want %0d", c, x));
	endtask : count_edges

	always @(posedge clock) begin
		if (res_valid === 1'b1) begin
			compares++;
			if (exp_q.size() == 0) fail("unexpected result");
			else begin
				e = exp_q.pop_front();
				m = msk_q.pop_front();
				if ((res_data & m) !== (e & m)) fail($sformatf("got %h want %h", res_data, e));
			end
		end
	end
	always @(posedge clock) begin
		cycles++;
		if (cycles == 90000) begin
			fail("timeout");
			report_and_stop();
		end
	end

	initial begin
		rstn = 1'b0;
		power_fail = 1'b0;
		errors = 0;
		compares = 0;
		cycles = 0;
		v = $urandom(32'h042A);
		// long enough for the crystal domain to see reset too
		repeat (48) @(posedge clock);
		rstn <= 1'b1;
		repeat (8) @(posedge clock);
		v = $urandom;
		wr = '{0: 8'h3E, 1: v[7:0], 2: v[15:8], default: 8'h00};
		xw(DEV_ADDR, 3, 1'b1);
		rd = '{0: v[7:0], 1: v[15:8], default: 8'h00};
		rk = '{default: 8'hFF};
		xr(8'h3E, 2);
		done("ram");
		wr = '{8'h3F, v[23:16], 8'h59, 8'h59, 8'h23, 8'h07, 8'h28, 8'h02, 8'h03};
		xw(DEV_ADDR, 9, 1'b1);
		// about 1.25 s: past the rollover, short of a second increment after it
		repeat (15 * DIV) @(posedge clock);
		rd = '{v[23:16], 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h03, 8'h03};
		rk = '{1: 8'hFE, default: 8'hFF};
		xr(8'h3F, 8);
		done("calendar");
		// set 11:59:59 pm in 12-hour form while halted, so no tick splits the update
		wr = '{0: 8'h00, 1: 8'hD9, 2: 8'h59, 3: 8'h71, 4: 8'h05, default: 8'h00};
		xw(DEV_ADDR, 5, 1'b1);
		wr[1] = 8'h59;
		xw(DEV_ADDR, 2, 1'b1);
		// first tick falls inside this wait, a second one can only touch the seconds lsb
		repeat (14 * DIV) @(posedge clock);
		rd = '{2: 8'h52, 3: 8'h06, default: 8'h00};
		rk = '{0: 8'hFE, default: 8'hFF};
		xr(8'h00, 4);
		done("twelve hour");
		wr = '{0: 8'h10, 1: v[7:0] | 8'h80, 2: 8'h80, 3: 8'hC0, default: 8'h00};
		xw(DEV_ADDR, 4, 1'b1);
		power_fail <= 1'b1;
		repeat (20) @(posedge clock);
		wr[1] = ~wr[1];
		xw(DEV_ADDR, 2, 1'b0);
		power_fail <= 1'b0;
		repeat (20) @(posedge clock);
		rd[0] = 8'h00;
		rk[0] = 8'h80;
		xr(-1, 1);
		rd[0] = v[7:0] | 8'h80;
		rk[0] = 8'hFF;
		xr(8'h10, 1);
		done("power fail");
		wr = '{0: 8'h3E, 1: ~v[7:0], default: 8'h00};
		xw(DEV_ADDR ^ 7'h01, 2, 1'b0);
		rd[0] = v[7:0];
		xr(8'h3E, 1);
		done("address");
		wr = '{0: 8'h07, 1: 8'h80, default: 8'h00};
		xw(DEV_ADDR, 2, 1'b1);
		repeat (100) @(posedge clock);
		chk(sq_line === 1'b1, "static level high");
		rd[0] = 8'h80;
		rk[0] = 8'h93;
		xr(8'h07, 1);
		wr[1] = 8'h00;
		xw(DEV_ADDR, 2, 1'b1);
		repeat (100) @(posedge clock);
		chk(sq_line === 1'b0, "static level low");
		for (int r = 0; r < 4; r++) begin
			wr[1] = 8'h10 | 8'(r) | (v[31:24] & 8'h6C);
			xw(DEV_ADDR, 2, 1'b1);
			repeat (50) @(posedge clock);
			count_edges(512 / dv[r]);
		end
		done("square");
		report_and_stop();
	end
endmodule : bcr_clock_calendar_bench
`default_nettype wire
